/* tmr_reload_timer.sv */
/*
 * cascadable 16-bit reload down-counter with register port and interrupt
 * assumes synchronous event inputs and a single-cycle strobe master
 */
// Overview of operation
// - stop-on-receive halts after first 4 bits
// - stop-on-receive ignored in oscillator trimming modes
// - start mode 00 gives no automatic start
// - start mode 01 starts at transmission end
// - modes 10/11 trim; rising edges start/stop
// - auto-restart reloads at zero, keeps counting; start mode 10 holds at zero
// - no auto-restart: stop at zero, wait start; start mode 10 runs on at zero
// - every underflow sets the interrupt flag
// - clock select 00 fast, 01 slow tick
// - clock select 10/11 cascade other underflows
// - start event loads counter from reload bytes
// - reload writes only act at next start or auto-restart
// - two read-only bytes show live count
// - two read-only bytes show neighbour count
`include "tmr_cfg.svh"
`default_nettype none
module tmr_reload_timer #(
    parameter int TICK_DIV = `TMR_TICK_DIV  // slow tick divider
) (
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    input  wire tmr_pkg::tmr_bus_type bus,
    output logic [7:0]                rdData,
    input  wire tmr_pkg::tmr_evt_type evt,
    input  wire logic [15:0]          neighbourCount,
    output logic                      underflowPulse,
    output logic                      irq,
    output logic                      running
);
    import tmr_pkg::*;

    // pick one byte of a word
    function automatic logic [7:0] pickByte(input logic [15:0] v,
                                            input logic hi);
        pickByte = hi ? v[15:8] : v[7:0];
    endfunction

    // write to one offset
    function automatic logic wrHit(input tmr_bus_type b,
                                   input logic [7:0] a);
        wrHit = b.wr && (b.addr == a);
    endfunction

    localparam int TW = $clog2(TICK_DIV);

    // storage
    tmr_ctl_type   ctl_q;      // control register
    logic [15:0]   reload_q;   // reload_value
    logic [15:0]   count_q;    // live counter
    logic [15:0]   count_d;
    tmr_state_type state_q;    // idle or counting
    tmr_state_type state_d;
    logic [0:0]    status_q;   // sticky underflow_irq_flag
    logic [0:0]    status_d;
    logic [0:0]    mask_q;     // interrupt enable
    logic [TW-1:0] tick_q;     // slow tick divider
    logic          lfoPrev_q;  // last oscillator level
    logic          uflow_q;    // registered underflow
    logic [7:0]    rd_q;       // read data

    // decode of the register port
    wire wrCtl    = wrHit(bus, `TMR_ADDR_CTL);
    wire wrRldHi  = wrHit(bus, `TMR_ADDR_RLD_HI);
    wire wrRldLo  = wrHit(bus, `TMR_ADDR_RLD_LO);
    wire wrStatus = wrHit(bus, `TMR_ADDR_STATUS);
    wire wrMask   = wrHit(bus, `TMR_ADDR_MASK);
    wire wrCmd    = wrHit(bus, `TMR_ADDR_CMD);
    wire cmdStart = wrCmd && bus.wdata[`TMR_CMD_START];
    wire cmdStop  = wrCmd && bus.wdata[`TMR_CMD_STOP];

    // control fields
    wire [1:0] startMode = ctl_q.startMode;
    wire [1:0] clockSel  = ctl_q.clockSelect;
    wire       autoRst   = ctl_q.autoRestart;
    wire       lfoMode   = startMode[1];
    wire       isRun     = (state_q == ST_RUN);

    // slow tick from the divider
    wire tickSlow = (tick_q == TW'(TICK_DIV - 1));

    // counting clock selection
    wire cntTick = (clockSel == `TMR_CLK_FAST)   ? 1'b1 :
                   (clockSel == `TMR_CLK_TICK)   ? tickSlow :
                   (clockSel == `TMR_CLK_CASC_A) ? evt.uflowA :
                   evt.uflowB;

    // oscillator rising edge
    wire lfoRise  = evt.lfoLevel && !lfoPrev_q;
    wire lfoStart = lfoMode && lfoRise && !isRun;
    wire lfoStop  = lfoMode && lfoRise && isRun;

    // start events; mode 00 adds no automatic source
    wire txStart = (startMode == `TMR_START_TX) && evt.txDone;
    wire startEv = cmdStart || txStart || lfoStart;

    // stop events; receive stop masked while trimming
    wire rxStop = ctl_q.stopOnReceive && !lfoMode && evt.rxFirst4;
    wire stopEv = cmdStop || rxStop || lfoStop;

    // a stop in the same cycle beats a start
    wire startGo = startEv && !stopEv;

    // counting step and zero detect
    wire runTick = isRun && cntTick;
    wire atZero  = (count_q == 16'h0000);
    wire noUflow = (startMode == `TMR_START_LFO_NU);
    wire uflow   = runTick && atZero && !noUflow && !startGo;

    // next counter value
    always_comb begin
        count_d = count_q;
        if (startGo) begin
            count_d = reload_q;
        end else if (uflow && autoRst) begin
            count_d = reload_q;
        end else if (runTick && !atZero) begin
            count_d = count_q - 16'h0001;
        end
    end

    // next run state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (startGo) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stopEv) begin
                    state_d = ST_IDLE;
                end else if (uflow && !autoRst) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    // sticky flag: a new underflow beats a clear
    assign status_d = (status_q & ~(wrStatus ? bus.wdata[0:0] : 1'b0))
                    | uflow;

    // read selection, unmapped reads zero
    wire [7:0] rdMux =
        (bus.addr == `TMR_ADDR_NB_HI)  ? pickByte(neighbourCount, 1'b1) :
        (bus.addr == `TMR_ADDR_NB_LO)  ? pickByte(neighbourCount, 1'b0) :
        (bus.addr == `TMR_ADDR_CTL)    ? (ctl_q & 8'hbb) :
        (bus.addr == `TMR_ADDR_RLD_HI) ? pickByte(reload_q, 1'b1) :
        (bus.addr == `TMR_ADDR_RLD_LO) ? pickByte(reload_q, 1'b0) :
        (bus.addr == `TMR_ADDR_CNT_HI) ? pickByte(count_q, 1'b1) :
        (bus.addr == `TMR_ADDR_CNT_LO) ? pickByte(count_q, 1'b0) :
        (bus.addr == `TMR_ADDR_STATUS) ? {7'h00, status_q} :
        (bus.addr == `TMR_ADDR_MASK)   ? {7'h00, mask_q} :
        8'h00;

    // control register, reserved bits kept zero
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctl_q <= `TMR_CTL_RST;
        end else if (wrCtl) begin
            ctl_q <= bus.wdata & 8'hbb;
        end
    end

    // reload bytes, only sampled by a start or an auto-restart reload
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reload_q <= `TMR_RLD_RST;
        end else if (wrRldHi) begin
            reload_q[15:8] <= bus.wdata;
        end else if (wrRldLo) begin
            reload_q[7:0] <= bus.wdata;
        end
    end

    // counter and state
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            count_q <= `TMR_CNT_RST;
            state_q <= ST_IDLE;
        end else begin
            count_q <= count_d;
            state_q <= state_d;
        end
    end

    // slow tick divider runs free
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tick_q <= '0;
        end else begin
            tick_q <= tickSlow ? '0 : tick_q + TW'(1);
        end
    end

    // edge history and underflow pulse
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lfoPrev_q <= 1'b0;
            uflow_q   <= 1'b0;
        end else begin
            lfoPrev_q <= evt.lfoLevel;
            uflow_q   <= uflow;
        end
    end

    // interrupt status and mask
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            status_q <= 1'b0;
            mask_q   <= 1'b0;
        end else begin
            status_q <= status_d;
            mask_q   <= wrMask ? bus.wdata[0:0] : mask_q;
        end
    end

    // read data, valid the cycle after the strobe
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rd_q <= 8'h00;
        end else begin
            rd_q <= bus.rd ? rdMux : 8'h00;
        end
    end

    // outputs
    assign rdData         = rd_q;
    assign underflowPulse = uflow_q;
    assign irq            = |(status_q & mask_q);
    assign running        = isRun;

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    // a read strobe at a given offset
    sequence s_rdAt(logic [7:0] a);
        bus.rd && bus.addr == a;
    endsequence

    property p_stopRx;
        isRun && rxStop |=> !isRun;
    endproperty
    a_stopRx: assert property (p_stopRx)
        else $error("receive stop missed");

    property p_rxIgnored;
        isRun && lfoMode && evt.rxFirst4 && !lfoRise && !cmdStop && !uflow
            |=> isRun;
    endproperty
    a_rxIgnored: assert property (p_rxIgnored)
        else $error("receive stop acted while trimming");

    property p_noAuto;
        !isRun && startMode == `TMR_START_NONE && !cmdStart |=> !isRun;
    endproperty
    a_noAuto: assert property (p_noAuto)
        else $error("timer started by itself");

    property p_txStart;
        txStart && !stopEv |=> isRun && count_q == $past(reload_q);
    endproperty
    a_txStart: assert property (p_txStart)
        else $error("no start at transmission end");

    property p_noUflow;
        isRun && noUflow |=> !underflowPulse;
    endproperty
    a_noUflow: assert property (p_noUflow)
        else $error("underflow in trimming without underflow");

    property p_reload;
        uflow && autoRst && !stopEv |=> isRun && count_q == $past(reload_q);
    endproperty
    a_reload: assert property (p_reload)
        else $error("auto restart did not reload");

    property p_stopZero;
        uflow && !autoRst |=> !isRun ##1 (!isRun || $past(startGo));
    endproperty
    a_stopZero: assert property (p_stopZero)
        else $error("timer kept running after zero");

    property p_flag;
        uflow |=> status_q[0] && underflowPulse;
    endproperty
    a_flag: assert property (p_flag)
        else $error("underflow flag not set");

    property p_fast;
        isRun && clockSel == `TMR_CLK_FAST && !atZero && !startGo && !stopEv
            |=> count_q == $past(count_q) - 16'h0001;
    endproperty
    a_fast: assert property (p_fast)
        else $error("fast clock did not decrement");

    property p_cascade;
        clockSel == `TMR_CLK_CASC_A && !evt.uflowA && !startGo
            |=> count_q == $past(count_q);
    endproperty
    a_cascade: assert property (p_cascade)
        else $error("cascade counted without underflow");

    property p_rldHold;
        (wrRldHi || wrRldLo) && !startGo && !runTick
            |=> count_q == $past(count_q);
    endproperty
    a_rldHold: assert property (p_rldHold)
        else $error("reload write disturbed count");

    property p_cntRead;
        s_rdAt(`TMR_ADDR_CNT_LO) |=> rdData == $past(count_q[7:0]);
    endproperty
    a_cntRead: assert property (p_cntRead)
        else $error("count low byte read wrong");

    property p_nbRead;
        s_rdAt(`TMR_ADDR_NB_HI) |=> rdData == $past(neighbourCount[15:8]);
    endproperty
    a_nbRead: assert property (p_nbRead)
        else $error("neighbour high byte read wrong");

    // a command start loads the reload value
    property p_cmdLoad;
        cmdStart && !stopEv |=> isRun && count_q == $past(reload_q);
    endproperty
    a_cmdLoad: assert property (p_cmdLoad)
        else $error("command start did not load");

    // no cascade pulse without an underflow the cycle before
    property p_pulseQuiet;
        !uflow |=> !underflowPulse;
    endproperty
    a_pulseQuiet: assert property (p_pulseQuiet)
        else $error("cascade pulse without underflow");

    // the flag stays set until a one is written to it
    property p_flagHold;
        status_q[0] && !(wrStatus && bus.wdata[0]) |=> status_q[0];
    endproperty
    a_flagHold: assert property (p_flagHold)
        else $error("underflow flag lost without clear");

    // a written one clears the flag unless an underflow lands
    property p_flagClear;
        wrStatus && bus.wdata[0] && !uflow |=> !status_q[0];
    endproperty
    a_flagClear: assert property (p_flagClear)
        else $error("underflow flag not cleared");

    // the slow tick leaves the count alone between ticks
    property p_slowHold;
        isRun && clockSel == `TMR_CLK_TICK && !tickSlow && !startGo
            |=> count_q == $past(count_q);
    endproperty
    a_slowHold: assert property (p_slowHold)
        else $error("slow clock counted between ticks");

    // high byte of the live count on a read
    property p_cntHiRead;
        s_rdAt(`TMR_ADDR_CNT_HI) |=> rdData == $past(count_q[15:8]);
    endproperty
    a_cntHiRead: assert property (p_cntHiRead)
        else $error("count high byte read wrong");

    // low byte of the neighbour count on a read
    property p_nbLoRead;
        s_rdAt(`TMR_ADDR_NB_LO) |=> rdData == $past(neighbourCount[7:0]);
    endproperty
    a_nbLoRead: assert property (p_nbLoRead)
        else $error("neighbour low byte read wrong");

endmodule // tmr_reload_timer
`default_nettype wire

/* tmr_cfg.svh */
/*
 * constants of the cascadable reload timer: offsets, fields, resets, counts
 * assumes byte-wide registers on an 8-bit address, included by bare name
 */
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH
// register offsets
`define TMR_ADDR_NB_HI   8'h17
`define TMR_ADDR_NB_LO   8'h18
`define TMR_ADDR_CTL     8'h19
`define TMR_ADDR_RLD_HI  8'h1a
`define TMR_ADDR_RLD_LO  8'h1b
`define TMR_ADDR_CNT_HI  8'h1c
`define TMR_ADDR_CNT_LO  8'h1d
`define TMR_ADDR_STATUS  8'h30
`define TMR_ADDR_MASK    8'h31
`define TMR_ADDR_CMD     8'h32
// command bits
`define TMR_CMD_START    0
`define TMR_CMD_STOP     1
// status / mask bit of the underflow flag
`define TMR_IRQ_UFLOW    0
// reset values
`define TMR_CTL_RST      8'h00
`define TMR_RLD_RST      16'h0000
`define TMR_CNT_RST      16'h0000
// control field values
`define TMR_START_NONE   2'h0
`define TMR_START_TX     2'h1
`define TMR_START_LFO_NU 2'h2
`define TMR_CLK_FAST     2'h0
`define TMR_CLK_TICK     2'h1
`define TMR_CLK_CASC_A   2'h2
// system cycles per slow tick (13.56 MHz / 64)
`define TMR_TICK_DIV     64
`endif

/* tmr_pkg.sv */
/*
 * types of the cascadable reload timer
 * assumes nothing beyond a SystemVerilog compiler
 */
`default_nettype none
package tmr_pkg;
    // one cycle of the register port
    typedef struct packed {
        logic [7:0] addr;   // register offset
        logic [7:0] wdata;  // write data
        logic       wr;     // write strobe
        logic       rd;     // read strobe
    } tmr_bus_type;
    // radio, oscillator and cascade events
    typedef struct packed {
        logic txDone;   // pulse: transmission finished
        logic rxFirst4; // pulse: first 4 bits received
        logic lfoLevel; // low_freq_oscillator level
        logic uflowA;   // pulse: first other timer underflow
        logic uflowB;   // pulse: second other timer underflow
    } tmr_evt_type;
    // control register layout
    typedef struct packed {
        logic       stopOnReceive;
        logic       rsv6;
        logic [1:0] startMode;
        logic       autoRestart;
        logic       rsv2;
        logic [1:0] clockSelect;
    } tmr_ctl_type;
    // run state
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } tmr_state_type;
endpackage
`default_nettype wire

/* test_tmr_reload_timer.sv */
/*
 * self-checking bench of the cascadable reload timer: register port, events, irq
 * assumes tmr_cfg.svh, tmr_pkg and tmr_reload_timer compiled before it
 */
`include "tmr_cfg.svh"
`default_nettype none
// compare two values, count and report
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); failures++; end end
module test_tmr_reload_timer;
    timeunit 1ns;
    timeprecision 1ps;
    import tmr_pkg::*;
    localparam int TICK = 4;                  // shortened slow tick divider
    localparam logic [4:0] TXD = 5'h10;       // event mask: transmission done
    localparam logic [4:0] RX4 = 5'h08;       // event mask: first 4 bits in
    localparam logic [4:0] LOW_FREQ_OSCILLATOR = 5'h04;       // event mask: oscillator edge
    localparam logic [4:0] UFA = 5'h02;       // event mask: first cascade
    localparam logic [4:0] UFB = 5'h01;       // event mask: second cascade
    localparam logic [7:0] GO   = 8'h01 << `TMR_CMD_START;   // start command
    localparam logic [7:0] HALT = 8'h01 << `TMR_CMD_STOP;    // stop command
    logic        clk_sys;        // system clock
    logic        nrst;           // reset, active low
    tmr_bus_type bus;            // register port request
    logic [7:0]  rdData;         // read data
    tmr_evt_type evt;            // event inputs
    logic [15:0] neighbourCount; // neighbour live count
    logic        underflowPulse; // cascade pulse out
    logic        irq;            // interrupt level
    logic        running;        // timer counting
    logic [7:0]  d;              // scratch read value
    int          n;              // scratch cycle count
    int          failures;       // mismatches
    int          n_compared;     // comparisons made
    // device under test
    tmr_reload_timer #(.TICK_DIV(TICK)) i_tmr_reload_timer (
        .clk_sys        (clk_sys),
        .nrst           (nrst),
        .bus            (bus),
        .rdData         (rdData),
        .evt            (evt),
        .neighbourCount (neighbourCount),
        .underflowPulse (underflowPulse),
        .irq            (irq),
        .running        (running)
    );
    // 100 mhz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // one-cycle write strobe
    task automatic regWrite(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
        #1;
    endtask
    // one-cycle read strobe, data taken the cycle after
    task automatic regRead(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1 v = rdData;
    endtask
    // read and compare
    task automatic regCheck(input logic [7:0] a, input logic [7:0] ex, input string nm);
        logic [7:0] v;
        regRead(a, v);
        `CHK(nm, ex, v)
    endtask
    // one-cycle event pulse
    task automatic pulse(input logic [4:0] m);
        @(posedge clk_sys);
        evt <= m;
        @(posedge clk_sys);
        evt <= '0;
        #1;
    endtask
    // bounded wait for the run state
    task automatic runIs(input logic ex, input string nm);
        for (int i = 0; i < 6 && running !== ex; i++) begin
            @(posedge clk_sys);
            #1;
        end
        `CHK(nm, ex, running)
    endtask
    // bounded wait for the cascade pulse
    task automatic waitPulse(input string nm);
        for (int i = 0; i < 200 && underflowPulse !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        `CHK(nm, 1'b1, underflowPulse)
    endtask
    // 16-bit reload through both bytes
    task automatic setReload(input logic [15:0] v);
        regWrite(`TMR_ADDR_RLD_HI, v[15:8]);
        regWrite(`TMR_ADDR_RLD_LO, v[7:0]);
    endtask
    // verdict and end of run
    task automatic summarize();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #50000;
        failures++;
        summarize();
    end
    // main sequence
    initial begin
        bus = '0;
        evt = '0;
        neighbourCount = 16'h0000;
        nrst = 1'b0;
        failures = 0;
        n_compared = 0;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        // reset values and an unmapped place
        regCheck(`TMR_ADDR_CTL, `TMR_CTL_RST, "control reset");
        regCheck(`TMR_ADDR_CNT_LO, 8'h00, "count low reset");
        regCheck(8'h40, 8'h00, "unmapped read");
        `CHK("irq reset", 1'b0, irq)
        // neighbour bytes are live and read-only
        @(posedge clk_sys);
        neighbourCount <= 16'hbeef;
        regWrite(`TMR_ADDR_NB_HI, 8'h12);
        regCheck(`TMR_ADDR_NB_HI, 8'hbe, "neighbour high");
        regCheck(`TMR_ADDR_NB_LO, 8'hef, "neighbour low");
        // reserved control bits read zero
        regWrite(`TMR_ADDR_CTL, 8'hff);
        regCheck(`TMR_ADDR_CTL, 8'hbb, "control reserved");
        // cascade on the second source, start loads reload
        regWrite(`TMR_ADDR_CTL, 8'h03);
        setReload(16'h0305);
        regWrite(`TMR_ADDR_CMD, GO);
        regCheck(`TMR_ADDR_CNT_HI, 8'h03, "count high loaded");
        regCheck(`TMR_ADDR_CNT_LO, 8'h05, "count low loaded");
        pulse(UFB);
        regCheck(`TMR_ADDR_CNT_LO, 8'h04, "second cascade tick");
        pulse(UFA);
        regCheck(`TMR_ADDR_CNT_LO, 8'h04, "other source ignored");
        regWrite(`TMR_ADDR_CTL, 8'h02);
        pulse(UFA);
        regCheck(`TMR_ADDR_CNT_LO, 8'h03, "first cascade tick");
        // reload write leaves the live count alone
        regWrite(`TMR_ADDR_RLD_LO, 8'h10);
        regCheck(`TMR_ADDR_CNT_LO, 8'h03, "count kept on reload write");
        regWrite(`TMR_ADDR_CMD, HALT);
        runIs(1'b0, "stop command");
        regWrite(`TMR_ADDR_CMD, GO);
        regCheck(`TMR_ADDR_CNT_LO, 8'h10, "new reload at start");
        // one-shot underflow on the fast clock, irq path
        regWrite(`TMR_ADDR_CTL, 8'h00);
        setReload(16'h0002);
        regWrite(`TMR_ADDR_STATUS, 8'h01);
        regWrite(`TMR_ADDR_MASK, 8'h01);
        regWrite(`TMR_ADDR_CMD, GO);
        waitPulse("underflow pulse");
        runIs(1'b0, "stop at zero");
        regCheck(`TMR_ADDR_CNT_LO, 8'h00, "held at zero");
        regCheck(`TMR_ADDR_STATUS, 8'h01, "flag set");
        `CHK("irq unmasked", 1'b1, irq)
        regWrite(`TMR_ADDR_MASK, 8'h00);
        @(posedge clk_sys);
        #1 `CHK("irq masked", 1'b0, irq)
        regWrite(`TMR_ADDR_MASK, 8'h01);
        regWrite(`TMR_ADDR_STATUS, 8'h01);
        @(posedge clk_sys);
        #1 `CHK("irq cleared", 1'b0, irq)
        // auto-restart period is reload plus one
        regWrite(`TMR_ADDR_CTL, 8'h08);
        setReload(16'h0003);
        regWrite(`TMR_ADDR_CMD, GO);
        waitPulse("first restart pulse");
        n = 0;
        do begin
            @(posedge clk_sys);
            #1 n++;
        end while (underflowPulse !== 1'b1 && n < 50);
        `CHK("restart period", 4, n)
        `CHK("still running", 1'b1, running)
        // slow tick: about one step per divider span
        regWrite(`TMR_ADDR_CTL, 8'h01);
        setReload(16'h0008);
        regWrite(`TMR_ADDR_CMD, GO);
        repeat (20) @(posedge clk_sys);
        regWrite(`TMR_ADDR_CMD, HALT);
        regRead(`TMR_ADDR_CNT_LO, d);
        `CHK("slow tick count", 1'b1, (d >= 8'h02 && d <= 8'h03))
        // stop on receive, both settings
        regWrite(`TMR_ADDR_CTL, 8'h80);
        setReload(16'hffff);
        regWrite(`TMR_ADDR_CMD, GO);
        pulse(RX4);
        runIs(1'b0, "stopped by receive");
        regCheck(`TMR_ADDR_CNT_HI, 8'hff, "count held after receive");
        regWrite(`TMR_ADDR_CTL, 8'h00);
        regWrite(`TMR_ADDR_CMD, GO);
        pulse(RX4);
        runIs(1'b1, "receive ignored");
        // automatic start modes
        regWrite(`TMR_ADDR_CMD, HALT);
        pulse(TXD);
        runIs(1'b0, "no automatic start");
        regWrite(`TMR_ADDR_CTL, 8'h10);
        pulse(TXD);
        runIs(1'b1, "start at transmit end");
        regWrite(`TMR_ADDR_CMD, HALT);
        // trimming without underflow, stop-on-receive ineffective
        regWrite(`TMR_ADDR_CTL, 8'ha0);
        setReload(16'h0001);
        regWrite(`TMR_ADDR_STATUS, 8'h01);
        pulse(LOW_FREQ_OSCILLATOR);
        runIs(1'b1, "trim start on edge");
        pulse(RX4);
        runIs(1'b1, "trim ignores receive");
        regCheck(`TMR_ADDR_STATUS, 8'h00, "trim no underflow");
        pulse(LOW_FREQ_OSCILLATOR);
        runIs(1'b0, "trim stop on edge");
        // trimming with underflow
        regWrite(`TMR_ADDR_CTL, 8'h30);
        pulse(LOW_FREQ_OSCILLATOR);
        waitPulse("trim underflow");
        summarize();
    end
endmodule // test_tmr_reload_timer
`default_nettype wire
